// ==== hdl/fieldbus_status_led.sv ====
// Top of the fieldbus status LED block: APB registers, priority select,
// millisecond tick, interrupt and the red/green duo LED drive.
// Assumes firmware keeps the condition register current; pins are synchronous.
`timescale 1ns/1ps
module fieldbus_status_led #(
    parameter int CLK_MHZ     = 50,
    parameter int TICK_CYCLES = CLK_MHZ * led_pkg::TICK_US
) (
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Duo LED and interrupt
    output logic             led_red,
    output logic             led_green,
    output logic             irq
);
    localparam int TW = $clog2(TICK_CYCLES);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    logic [TW-1:0]             tick_cnt_reg;
    logic                      tick_reg;
    logic                      pready_reg;
    logic                      pslverr_reg;
    logic [31:0]               prdata_reg;
    logic [31:0]               prdata_next;
    led_pkg::mode_type         mode_reg;
    logic [31:0]               cond_reg;
    logic [led_pkg::IRQ_W-1:0] irq_en_reg;
    logic [led_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [led_pkg::IRQ_W-1:0] irq_stat_next;
    logic [led_pkg::IRQ_W-1:0] irq_ev;
    logic [led_pkg::IRQ_W-1:0] irq_clr;
    logic                      bus_off_prev_reg;
    logic                      err_ev_prev_reg;
    led_pkg::pat_type          pat_reg;
    led_pkg::col_type          col_reg;
    led_pkg::pat_type          pat_next;
    led_pkg::col_type          col_next;
    logic                      ind_change;
    logic                      lit;
    logic                      irq_reg;
    logic                      led_red_reg;
    logic                      led_green_reg;
    logic                      access;
    logic                      commit;

    assign pready    = pready_reg;
    assign pslverr   = pslverr_reg;
    assign prdata    = prdata_reg;
    assign led_red   = led_red_reg;
    assign led_green = led_green_reg;
    assign irq       = irq_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else if (ce) begin
            if (tick_cnt_reg == TICK_LAST) begin
                tick_cnt_reg <= '0;
                tick_reg     <= 1'b1;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 1'b1;
                tick_reg     <= 1'b0;
            end
        end
    end

    // Address decode, shared by write commit and error answer
    function automatic logic addr_ok(logic [7:0] a, logic wr);
        unique case (a)
            led_pkg::ADDR_CTRL,
            led_pkg::ADDR_COND,
            led_pkg::ADDR_IRQ_EN:   return 1'b1;
            led_pkg::ADDR_STATE,
            led_pkg::ADDR_IRQ_STAT: return !wr;
            led_pkg::ADDR_IRQ_CLR:  return wr;
            default:                return 1'b0;
        endcase
    endfunction

    // One wait state: answer flops are loaded in the first access cycle
    assign access = psel && penable;
    assign commit = access && pready_reg && pwrite && addr_ok(paddr, pwrite);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else if (ce) begin
            pready_reg  <= access && !pready_reg;
            pslverr_reg <= access && !pready_reg && !addr_ok(paddr, pwrite);
            if (access && !pready_reg && !pwrite)
                prdata_reg <= prdata_next;
            else
                prdata_reg <= '0;
        end
    end

    always_comb begin
        prdata_next = '0;
        unique case (paddr)
            led_pkg::ADDR_CTRL:     prdata_next[1:0] = mode_reg;
            led_pkg::ADDR_COND:     prdata_next = cond_reg;
            led_pkg::ADDR_STATE:    prdata_next[5:0] = {led_red_reg, led_green_reg, col_reg, pat_reg};
            led_pkg::ADDR_IRQ_STAT: prdata_next[led_pkg::IRQ_W-1:0] = irq_stat_reg;
            led_pkg::ADDR_IRQ_EN:   prdata_next[led_pkg::IRQ_W-1:0] = irq_en_reg;
            default:                prdata_next = '0;
        endcase
    end

    // Control, condition and interrupt enable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= led_pkg::mode_type'(led_pkg::CTRL_RESET);
        end else if (ce && commit && paddr == led_pkg::ADDR_CTRL) begin
            mode_reg <= led_pkg::mode_type'(pwdata[1:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_reg <= '0;
        end else if (ce && commit && paddr == led_pkg::ADDR_COND) begin
            cond_reg <= pwdata & led_pkg::COND_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_reg <= '0;
        end else if (ce && commit && paddr == led_pkg::ADDR_IRQ_EN) begin
            irq_en_reg <= pwdata[led_pkg::IRQ_W-1:0];
        end
    end

    // CANopen master selection, reset ranked first, then bus-off
    function automatic logic [3:0] sel_canopen(logic [31:0] c);
        if (c[led_pkg::C_CAN_RESET])
            return {led_pkg::COL_GREEN, led_pkg::PAT_OFF};
        if (c[led_pkg::C_CAN_BUS_OFF])
            return {led_pkg::COL_RED, led_pkg::PAT_ON};
        if (c[led_pkg::C_CAN_ERR_EV])
            return {led_pkg::COL_RED, led_pkg::PAT_DOUBLE};
        if (c[led_pkg::C_CAN_WARN])
            return {led_pkg::COL_RED, led_pkg::PAT_SINGLE};
        if (c[led_pkg::C_CAN_OPER])
            return {led_pkg::COL_GREEN, led_pkg::PAT_ON};
        if (c[led_pkg::C_CAN_PREOP])
            return {led_pkg::COL_GREEN, led_pkg::PAT_BLINK};
        if (c[led_pkg::C_CAN_STOPPED])
            return {led_pkg::COL_GREEN, led_pkg::PAT_SINGLE};
        return {led_pkg::COL_GREEN, led_pkg::PAT_OFF};
    endfunction

    // Bus master communication indicator
    function automatic logic [3:0] sel_master(logic [31:0] c);
        if (c[led_pkg::C_M_DISC])
            return {led_pkg::COL_RED, led_pkg::PAT_ON};
        if (c[led_pkg::C_M_LOST])
            return {led_pkg::COL_RED, led_pkg::PAT_CYCLIC};
        if (c[led_pkg::C_M_NO_CFG] || c[led_pkg::C_M_STACK_ERR])
            return {led_pkg::COL_GREEN, led_pkg::PAT_ACYCLIC};
        if (c[led_pkg::C_M_ALL_OK])
            return {led_pkg::COL_GREEN, led_pkg::PAT_ON};
        if (c[led_pkg::C_M_NOT_REL])
            return {led_pkg::COL_GREEN, led_pkg::PAT_CYCLIC};
        return {led_pkg::COL_GREEN, led_pkg::PAT_OFF};
    endfunction

    // Bus slave communication indicator
    function automatic logic [3:0] sel_slave(logic [31:0] c);
        if (c[led_pkg::C_S_WRONG_CFG])
            return {led_pkg::COL_RED, led_pkg::PAT_ON};
        if (c[led_pkg::C_S_NOT_CFG])
            return {led_pkg::COL_RED, led_pkg::PAT_ACYCLIC};
        if (c[led_pkg::C_S_STOP] || c[led_pkg::C_S_CONN_ERR])
            return {led_pkg::COL_RED, led_pkg::PAT_CYCLIC};
        if (c[led_pkg::C_S_RUN])
            return {led_pkg::COL_GREEN, led_pkg::PAT_ON};
        return {led_pkg::COL_GREEN, led_pkg::PAT_OFF};
    endfunction

    always_comb begin
        logic [3:0] s;
        s = '0;
        unique case (mode_reg)
            led_pkg::MODE_MASTER:  s = sel_master(cond_reg);
            led_pkg::MODE_SLAVE:   s = sel_slave(cond_reg);
            led_pkg::MODE_CANOPEN: s = sel_canopen(cond_reg);
            led_pkg::MODE_NONE:    s = {led_pkg::COL_GREEN, led_pkg::PAT_OFF};
        endcase
        col_next = led_pkg::col_type'(s[3]);
        pat_next = led_pkg::pat_type'(s[2:0]);
    end

    assign ind_change = (pat_next != pat_reg) || (col_next != col_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pat_reg <= led_pkg::PAT_OFF;
            col_reg <= led_pkg::COL_GREEN;
        end else if (ce && ind_change) begin
            pat_reg <= pat_next;
            col_reg <= col_next;
        end
    end

    led_pattern_gen u_pattern (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .tick    (tick_reg),
        .restart (ind_change),
        .pattern (pat_reg),
        .lit     (lit)
    );

    // one colour lit at a time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_red_reg   <= 1'b0;
            led_green_reg <= 1'b0;
        end else if (ce) begin
            led_red_reg   <= lit && (col_reg == led_pkg::COL_RED);
            led_green_reg <= lit && (col_reg == led_pkg::COL_GREEN);
        end
    end

    // Events: indication change and rising bus-off or error-control bit
    always_comb begin
        irq_ev = '0;
        irq_ev[led_pkg::IRQ_CHANGE]  = ind_change;
        irq_ev[led_pkg::IRQ_BUS_OFF] = cond_reg[led_pkg::C_CAN_BUS_OFF] && !bus_off_prev_reg;
        irq_ev[led_pkg::IRQ_ERR_EV]  = cond_reg[led_pkg::C_CAN_ERR_EV] && !err_ev_prev_reg;
        irq_clr = '0;
        if (commit && paddr == led_pkg::ADDR_IRQ_CLR)
            irq_clr = pwdata[led_pkg::IRQ_W-1:0];
        // Set beats clear so a same-cycle event survives
        irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_off_prev_reg <= 1'b0;
            err_ev_prev_reg  <= 1'b0;
            irq_stat_reg     <= '0;
            irq_reg          <= 1'b0;
        end else if (ce) begin
            bus_off_prev_reg <= cond_reg[led_pkg::C_CAN_BUS_OFF];
            err_ev_prev_reg  <= cond_reg[led_pkg::C_CAN_ERR_EV];
            irq_stat_reg     <= irq_stat_next;
            irq_reg          <= |(irq_stat_next & irq_en_reg);
        end
    end
endmodule

// ==== hdl/led_pattern_gen.sv ====
// Phase sequencer that turns a pattern code into a lit/dark level.
// Assumes a one-cycle tick each millisecond and a restart pulse on change.
`timescale 1ns/1ps
module led_pattern_gen (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    // Timing and selection
    input  wire logic              tick,
    input  wire logic              restart,
    input  wire led_pkg::pat_type  pattern,
    // Level
    output logic                   lit
);
    logic [led_pkg::MS_W-1:0] ms_reg;
    led_pkg::phase_type       phase_reg;

    function automatic logic [led_pkg::MS_W-1:0] phase_ms(led_pkg::pat_type p, led_pkg::phase_type ph);
        int t;
        t = led_pkg::FLASH_MS;
        unique case (p)
            led_pkg::PAT_FLICKER: t = led_pkg::FLICKER_MS;
            led_pkg::PAT_SINGLE:  t = (ph == led_pkg::PH_DARK_A) ? led_pkg::LONG_OFF_MS : led_pkg::FLASH_MS;
            led_pkg::PAT_DOUBLE:  t = (ph == led_pkg::PH_DARK_B) ? led_pkg::LONG_OFF_MS : led_pkg::FLASH_MS;
            led_pkg::PAT_CYCLIC:  t = ph[0] ? led_pkg::CYCLIC_OFF_MS : led_pkg::CYCLIC_ON_MS;
            led_pkg::PAT_ACYCLIC: t = (ph == led_pkg::PH_DARK_B) ? led_pkg::ACYC_LONG_MS :
                                      (ph == led_pkg::PH_DARK_A) ? led_pkg::ACYC_GAP_MS : led_pkg::ACYC_SHORT_MS;
            default:              t = led_pkg::FLASH_MS;
        endcase
        return t[led_pkg::MS_W-1:0];
    endfunction

    function automatic logic four_phase(led_pkg::pat_type p);
        return (p == led_pkg::PAT_DOUBLE) || (p == led_pkg::PAT_ACYCLIC);
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_reg    <= '0;
            phase_reg <= led_pkg::PH_LIT_A;
        end else if (ce) begin
            if (restart) begin
                ms_reg    <= '0;
                phase_reg <= led_pkg::PH_LIT_A;
            end else if (tick) begin
                if (ms_reg >= phase_ms(pattern, phase_reg) - 1'b1) begin
                    ms_reg <= '0;
                    if (phase_reg == led_pkg::PH_DARK_B || (phase_reg == led_pkg::PH_DARK_A && !four_phase(pattern)))
                        phase_reg <= led_pkg::PH_LIT_A;
                    else
                        phase_reg <= led_pkg::phase_type'(phase_reg + 2'b01);
                end else begin
                    ms_reg <= ms_reg + 1'b1;
                end
            end
        end
    end

    always_comb begin
        unique case (pattern)
            led_pkg::PAT_OFF: lit = 1'b0;
            led_pkg::PAT_ON:  lit = 1'b1;
            default:          lit = !phase_reg[0];
        endcase
    end
endmodule

// ==== hdl/led_pkg.sv ====
// Constants, types and register map of the fieldbus status LED block.
// Assumes one 50 MHz clock and firmware that posts status bits over APB.
package led_pkg;
    localparam int          TICK_US        = 1000;
    localparam int          MS_W           = 11;
    localparam int          FLICKER_MS     = 50;
    localparam int          FLASH_MS       = 200;
    localparam int          LONG_OFF_MS    = 1000;
    localparam int          CYCLIC_ON_MS   = 250;
    localparam int          CYCLIC_OFF_MS  = 250;
    localparam int          ACYC_SHORT_MS  = 50;
    localparam int          ACYC_GAP_MS    = 150;
    localparam int          ACYC_LONG_MS   = 750;
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_COND      = 8'h04;
    localparam logic [7:0]  ADDR_STATE     = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_EN    = 8'h10;
    localparam logic [7:0]  ADDR_IRQ_CLR   = 8'h14;
    localparam int          C_CAN_RESET    = 0;
    localparam int          C_CAN_STOPPED  = 1;
    localparam int          C_CAN_PREOP    = 2;
    localparam int          C_CAN_OPER     = 3;
    localparam int          C_CAN_WARN     = 4;
    localparam int          C_CAN_ERR_EV   = 5;
    localparam int          C_CAN_BUS_OFF  = 6;
    localparam int          C_M_NO_CFG     = 8;
    localparam int          C_M_STACK_ERR  = 9;
    localparam int          C_M_NOT_REL    = 10;
    localparam int          C_M_ALL_OK     = 11;
    localparam int          C_M_LOST       = 12;
    localparam int          C_M_DISC       = 13;
    localparam int          C_S_RUN        = 16;
    localparam int          C_S_WRONG_CFG  = 17;
    localparam int          C_S_STOP       = 18;
    localparam int          C_S_CONN_ERR   = 19;
    localparam int          C_S_NOT_CFG    = 20;
    localparam logic [31:0] COND_MASK      = 32'h001F3F7F;
    localparam int          IRQ_W          = 3;
    localparam int          IRQ_CHANGE     = 0;
    localparam int          IRQ_BUS_OFF    = 1;
    localparam int          IRQ_ERR_EV     = 2;
    localparam logic [1:0]  CTRL_RESET     = 2'h0;
    typedef enum logic [1:0] {
        MODE_MASTER = 2'b00, MODE_SLAVE = 2'b01, MODE_CANOPEN = 2'b10, MODE_NONE = 2'b11
    } mode_type;
    typedef enum logic [2:0] {
        PAT_OFF = 3'b000, PAT_ON = 3'b001, PAT_FLICKER = 3'b010, PAT_BLINK = 3'b011,
        PAT_SINGLE = 3'b100, PAT_DOUBLE = 3'b101, PAT_CYCLIC = 3'b110, PAT_ACYCLIC = 3'b111
    } pat_type;
    typedef enum logic {
        COL_GREEN = 1'b0, COL_RED = 1'b1
    } col_type;
    typedef enum logic [1:0] {
        PH_LIT_A = 2'b00, PH_DARK_A = 2'b01, PH_LIT_B = 2'b10, PH_DARK_B = 2'b11
    } phase_type;
endpackage

// ==== verification/fieldbus_status_led_assertions.sv ====
// Checker for the status LED block: APB handshake, reset state and LED phase timing.
// Assumes one clock domain with ce held high by the bench.
`timescale 1ns/1ps
module fieldbus_status_led_assertions #(
    parameter int TICK_CYCLES = 10
) (
    // Clock, reset, enable
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // LED and interrupt
    input wire logic        led_red,
    input wire logic        led_green,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic lit     = led_red | led_green;
    wire logic wr_done = psel & penable & pready & pwrite;
    logic      lit_q;
    int        run_cnt;
    int        chg_cnt;
    // First two runs after a write may be cut by phase restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lit_q   <= 1'b0;
            run_cnt <= 0;
            chg_cnt <= 0;
        end else begin
            lit_q   <= lit;
            run_cnt <= (lit != lit_q) ? 1 : run_cnt + 1;
            if (wr_done) begin
                chg_cnt <= 0;
            end else if (lit != lit_q && chg_cnt < 2) begin
                chg_cnt <= chg_cnt + 1;
            end
        end
    end
    property p_one_colour; !(led_red && led_green); endproperty
    a_one_colour: assert property (p_one_colour) else $error("both colours lit");
    property p_reset_dark; $rose(presetn) |-> !lit && !irq; endproperty
    a_reset_dark: assert property (p_reset_dark) else $error("outputs active after reset");
    property p_phase_len; (lit != lit_q) && chg_cnt == 2 |-> run_cnt % TICK_CYCLES == 0 && run_cnt >= 50 * TICK_CYCLES;
    endproperty
    a_phase_len: assert property (p_phase_len) else $error("LED phase not whole ticks");
    property p_apb_wait; ce && psel && !penable |=> !pready ##1 pready; endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("pready not on second access cycle");
    property p_ready_single; pready |=> !pready; endproperty
    a_ready_single: assert property (p_ready_single) else $error("pready longer than one cycle");
    property p_ready_access; pready |-> psel && penable; endproperty
    a_ready_access: assert property (p_ready_access) else $error("pready outside access");
    property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
    property p_err_unmapped; pready && paddr > 8'h14 |-> pslverr; endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access accepted");
    property p_irq_masked; wr_done && paddr == led_pkg::ADDR_IRQ_EN && pwdata == 32'h0 |=> ##1 !irq [*3];
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq high while masked");
    c_phase: cover property ((lit != lit_q) && chg_cnt == 2);
    c_slverr: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
endmodule
bind fieldbus_status_led fieldbus_status_led_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_fieldbus_status_led_assertions (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .led_red(led_red), .led_green(led_green), .irq(irq));

// ==== verification/fieldbus_status_led_patterns_test.sv ====
// Bench for the status LED block: APB tasks, indication table, pattern timing, interrupt.
// Assumes ce held high and a millisecond tick shortened to TICK clocks.
`timescale 1ns/1ps
module fieldbus_status_led_patterns_test;
    localparam int          TICK = 10;
    localparam logic [1:0]  MD [28] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
        2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3};
    localparam logic [23:0] CM [28] = '{24'h000001, 24'h000002, 24'h000004, 24'h000008, 24'h000010,
        24'h000020, 24'h000040, 24'h000049, 24'h000048, 24'h000038, 24'h000014, 24'h000100, 24'h000200,
        24'h000400, 24'h000800, 24'h001000, 24'h002000, 24'h003800, 24'h001100, 24'h000900, 24'h010000,
        24'h020000, 24'h040000, 24'h080000, 24'h100000, 24'h030000, 24'h140000, 24'h000008};
    localparam logic [3:0]  EX [28] = '{4'h0, 4'h4, 4'h3, 4'h1, 4'hC, 4'hD, 4'h9, 4'h0, 4'h9, 4'hD, 4'hC,
        4'h7, 4'h7, 4'h6, 4'h1, 4'hE, 4'h9, 4'h9, 4'hE, 4'h7, 4'h1, 4'h9, 4'hE, 4'hE, 4'hF, 4'h9, 4'hF, 4'h0};
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rdv;
    logic        pready, pslverr, led_red, led_green, irq, lit, both_seen;
    int          error_cnt = 0;
    int          total_checks = 0;
    fieldbus_status_led #(.TICK_CYCLES(TICK)) i_fieldbus_status_led (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .led_red(led_red), .led_green(led_green), .irq(irq));
    led_duo_model i_led_duo_model (.pclk(pclk), .led_red(led_red), .led_green(led_green), .lit(lit),
        .both_seen(both_seen));
    initial begin
        forever #10 pclk = ~pclk;
    end
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp, input string what);
        total_checks++;
        if (got != exp) begin
            error_cnt++;
            $display("ERROR %0t %s lasted %0d cycles, expected %0d", $time, what, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Idle cycle first, so psel is never driven twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic e);
        int k;
        k = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge pclk);
            k++;
        end
        rdv = prdata;
        chk_word({30'h0, pready, pslverr}, {30'h0, 1'b1, e}, "apb answer");
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0, e);
        chk_word(rdv & m, exp, "read");
    endtask
    task automatic run_len(input logic lvl, input int exp, input int cap, input string what);
        int c;
        c = 0;
        while (lit === lvl && c < cap) begin
            @(posedge pclk);
            c++;
        end
        chk_cnt(c, exp, what);
    endtask
    // First lit phase is skipped: tick alignment may shorten it
    task automatic timing(input logic [1:0] m, input logic [31:0] c, input int ph[4], input int np, input string nm);
        int k;
        k = 0;
        apb(1'b1, led_pkg::ADDR_CTRL, {30'h0, m}, 1'b0);
        apb(1'b1, led_pkg::ADDR_COND, 32'h0, 1'b0);
        apb(1'b1, led_pkg::ADDR_COND, c, 1'b0);
        while (lit !== 1'b1 && k < 5) begin
            @(posedge pclk);
            k++;
        end
        while (lit === 1'b1 && np > 0 && k < 20000) begin
            @(posedge pclk);
            k++;
        end
        for (int i = 0; i < np; i++) begin
            run_len(i[0], ph[i], ph[i] + TICK, nm);
        end
        $display("test %s done", nm);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(led_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h0, 1'b0);
        rd(led_pkg::ADDR_COND, 32'hFFFFFFFF, 32'h0, 1'b0);
        rd(led_pkg::ADDR_STATE, 32'hFFFFFFFF, 32'h0, 1'b0);
        rd(led_pkg::ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h0, 1'b0);
        rd(led_pkg::ADDR_IRQ_EN, 32'hFFFFFFFF, 32'h0, 1'b0);
        apb(1'b1, led_pkg::ADDR_COND, 32'hFFFFFFFF, 1'b0);
        rd(led_pkg::ADDR_COND, 32'hFFFFFFFF, led_pkg::COND_MASK, 1'b0);
        rd(8'h18, 32'hFFFFFFFF, 32'h0, 1'b1);
        apb(1'b1, led_pkg::ADDR_STATE, 32'hFFFFFFFF, 1'b1);
        rd(led_pkg::ADDR_IRQ_CLR, 32'hFFFFFFFF, 32'h0, 1'b1);
        $display("test registers done");
        for (int i = 0; i < 28; i++) begin
            apb(1'b1, led_pkg::ADDR_CTRL, {30'h0, MD[i]}, 1'b0);
            apb(1'b1, led_pkg::ADDR_COND, 32'h0, 1'b0);
            apb(1'b1, led_pkg::ADDR_COND, {8'h00, CM[i]}, 1'b0);
            repeat (3) @(posedge pclk);
            chk_word({30'h0, led_red, led_green}, {30'h0, EX[i][3], ~EX[i][3]} & {32{EX[i][2:0] != 3'h0}},
                "led pins");
            rd(led_pkg::ADDR_STATE, 32'hF, {28'h0, EX[i]}, 1'b0);
        end
        $display("test indication table done");
        timing(2'h2, 32'h2, '{10000, 2000, 0, 0}, 2, "single flash");
        timing(2'h2, 32'h4, '{2000, 2000, 0, 0}, 2, "blinking");
        timing(2'h2, 32'h20, '{2000, 2000, 10000, 2000}, 4, "double flash");
        timing(2'h0, 32'h400, '{2500, 2500, 0, 0}, 2, "cyclic");
        timing(2'h0, 32'h100, '{1500, 500, 7500, 500}, 4, "acyclic");
        timing(2'h2, 32'h8, '{0, 0, 0, 0}, 0, "steady start");
        run_len(1'b1, 3000, 3000, "steady on");
        apb(1'b1, led_pkg::ADDR_COND, 32'h1, 1'b0);
        repeat (3) @(posedge pclk);
        run_len(1'b0, 3000, 3000, "steady off");
        apb(1'b1, led_pkg::ADDR_IRQ_CLR, 32'h7, 1'b0);
        rd(led_pkg::ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h0, 1'b0);
        apb(1'b1, led_pkg::ADDR_IRQ_EN, 32'h7, 1'b0);
        apb(1'b1, led_pkg::ADDR_COND, 32'h40, 1'b0);
        repeat (3) @(posedge pclk);
        chk_word({31'h0, irq}, 32'h1, "irq raised");
        rd(led_pkg::ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h3, 1'b0);
        apb(1'b1, led_pkg::ADDR_IRQ_EN, 32'h0, 1'b0);
        repeat (3) @(posedge pclk);
        chk_word({31'h0, irq}, 32'h0, "irq masked");
        rd(led_pkg::ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h3, 1'b0);
        apb(1'b1, led_pkg::ADDR_IRQ_CLR, 32'h3, 1'b0);
        rd(led_pkg::ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h0, 1'b0);
        apb(1'b1, led_pkg::ADDR_IRQ_EN, 32'h4, 1'b0);
        apb(1'b1, led_pkg::ADDR_COND, 32'h20, 1'b0);
        repeat (3) @(posedge pclk);
        chk_word({31'h0, irq}, 32'h1, "irq error event");
        rd(led_pkg::ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h5, 1'b0);
        apb(1'b1, led_pkg::ADDR_IRQ_CLR, 32'h4, 1'b0);
        repeat (3) @(posedge pclk);
        chk_word({31'h0, irq}, 32'h0, "irq cleared");
        $display("test interrupt done");
        chk_word({31'h0, both_seen}, 32'h0, "both colours");
        tally_and_finish();
    end
    initial begin
        repeat (90000) @(posedge pclk);
        error_cnt++;
        $display("ERROR %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule

// ==== verification/led_duo_model.sv ====
// Red/green duo LED: reports lit level and any both-colours fault.
// Assumes the LED pins change synchronously to pclk.
`timescale 1ns/1ps
module led_duo_model (
    // Clock
    input  wire logic pclk,
    // LED pins
    input  wire logic led_red,
    input  wire logic led_green,
    // Observed state
    output logic      lit,
    output logic      both_seen
);
    assign lit = led_red | led_green;
    initial both_seen = 1'b0;
    always @(posedge pclk) begin
        if (led_red && led_green) begin
            both_seen <= 1'b1;
        end
    end
endmodule
